// ==== bench/tspf_flash_model.sv ====
// flash partner for the table inserter: 1 MByte byte store, answers each read
// assumes each read is a one-cycle pulse, a new pulse restarts it; slow adds five wait cycles before the answer
`timescale 1ns/1ns
`default_nettype none
module tspf_flash_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slow,
  input  wire logic        flashRd_q,
  input  wire logic [19:0] flashAddr_q,
  output var  logic [7:0]  flashData,
  output var  logic        flashValid
);
  logic [7:0]  mem [0:(1<<20)-1]; // whole flash
  logic [19:0] addr;
  logic        busy;
  int          waitCnt;

  initial begin
    for (int a = 0; a < (1<<20); a++) mem[a] = 8'hff; // erased flash
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy       <= 1'b0;
      flashValid <= 1'b0;
      flashData  <= 8'h00;
    end else if (flashRd_q) begin
      busy       <= 1'b1;
      addr       <= flashAddr_q;
      waitCnt    <= slow ? 5 : 0;
      flashValid <= 1'b0;
      flashData  <= ~flashData;
    end else if (busy && waitCnt > 0) begin
      waitCnt    <= waitCnt - 1;
      flashValid <= 1'b0;
      flashData  <= ~flashData;
    end else if (busy) begin
      busy       <= 1'b0;
      flashValid <= 1'b1;
      flashData  <= mem[addr];
    end else begin
      // toggling data so a stale byte never looks valid
      flashValid <= 1'b0;
      flashData  <= ~flashData;
    end
  end

  task slot(input int s, input logic [15:0] p, input logic [7:0] ins, input logic [7:0] tim);
    int b;
    b = s * 204;
    for (int i = 4; i < 188; i++) mem[b+i] = s[7:0] ^ i[7:0];
    mem[b] = 8'h47;
    mem[b+1] = p[15:8];
    mem[b+2] = p[7:0];
    mem[b+3] = 8'h10; // counter field zero
    mem[b+188] = ins;
    mem[b+189] = tim;
  endtask : slot

  task build(input logic [7:0] t4);
    for (int s = 0; s < 320; s++) begin
      for (int i = 0; i < 204; i++) begin
        mem[s*204+i] = i == 0 ? 8'h47 : i == 1 ? 8'h1f : i == 3 ? 8'h10 :
                       (i == 188 || i == 189) ? 8'h00 : 8'hff; // null packets first
      end
    end
    for (int i = 0; i < 4; i++) mem[4+i] = 8'h61 + i[7:0]; // short project name
    slot(4, 16'h0000, 8'h01, t4); // association table slot
    slot(280, 16'h0123, 8'h01, 8'h00); // user packets
    slot(281, 16'h1fff, 8'h01, 8'hff); // end marker even with insert set
    slot(300, 16'h0777, 8'h01, 8'h00); // past the end, never reached
  endtask : build
endmodule : tspf_flash_model
`default_nettype wire

// ==== bench/tspf_top_tb.sv ====
// testbench for the stream filter, remapper and table inserter
// assumes the flash partner model and a 20 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tspf_top_tb;
  import tspf_pkg::*;
  localparam int TICK = 50;
  logic        clk       = 1'b0;
  logic        resetn    = 1'b0;
  tspf_word_t  inWord    = '0;
  logic        inValid   = 1'b0;
  logic        cfgWe     = 1'b0;
  logic [13:0] cfgAddr   = '0;
  logic [7:0]  cfgData   = '0;
  logic        slow      = 1'b0;
  logic        sawFull   = 1'b0;
  logic        inReady, flashRd_q, flashValid, outValid_q, outSop_q;
  logic [19:0] flashAddr_q;
  logic [7:0]  flashData, outData_q, outClkCont_q;
  logic [8:0]  obs[$];
  int          sopAt[$];
  int          cyc       = 0;
  int          t0        = 0;
  int          n_fail    = 0;
  int          cmp_count = 0;

  always #25 clk = ~clk;

  tspf_top #(.TICK_CYC(TICK), .FIFO_DEPTH(32)) tspf_top_inst (
    .clk(clk), .resetn(resetn), .inWord(inWord), .inValid(inValid), .inReady(inReady),
    .cfgWe(cfgWe), .cfgAddr(cfgAddr), .cfgData(cfgData), .flashRd_q(flashRd_q),
    .flashAddr_q(flashAddr_q), .flashData(flashData), .flashValid(flashValid),
    .outValid_q(outValid_q), .outSop_q(outSop_q), .outData_q(outData_q),
    .outClkCont_q(outClkCont_q));

  tspf_flash_model tspf_flash_model_inst (
    .clk(clk), .resetn(resetn), .slow(slow), .flashRd_q(flashRd_q),
    .flashAddr_q(flashAddr_q), .flashData(flashData), .flashValid(flashValid));

  // registered outputs, so the pre-edge value is the settled one
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (outValid_q === 1'b1) begin
      obs.push_back({outSop_q, outData_q});
      if (outSop_q === 1'b1) sopAt.push_back(cyc - t0);
    end
  end

  task chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task cfg(input int a, input logic [7:0] d);
    cfgWe <= 1'b1;
    cfgAddr <= a[13:0];
    cfgData <= d;
    @(posedge clk);
  endtask : cfg

  task wrPid(input int a, input logic [15:0] v);
    cfg(a, v[15:8]);
    cfg(a + 1, v[7:0]);
  endtask : wrPid

  task cfgEnd();
    cfgWe <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : cfgEnd

  // arrays are not reset, so every entry of regions 0 and 1 is written before the unit is used
  task fill(input int r);
    for (int i = 0; i < 254; i++) wrPid(r * 1024 + 4 + 2 * i, 16'h1ffe);
    for (int i = 0; i < 128; i++) begin
      wrPid(r * 1024 + 512 + 4 * i, 16'h0555);
      wrPid(r * 1024 + 514 + 4 * i, 16'h0555);
    end
  endtask : fill

  task send(input logic [2:0] port, input logic [15:0] p);
    @(posedge clk);
    for (int i = 0; i < 188; i++) begin
      inWord <= '{sop: i == 0, port: port,
                  data: i == 0 ? 8'h47 : i == 1 ? p[15:8] : i == 2 ? p[7:0] :
                        i == 3 ? 8'h10 : i[7:0]};
      inValid <= 1'b1;
      @(posedge clk);
      while (inReady !== 1'b1) begin
        sawFull = 1'b1;
        @(posedge clk);
      end
    end
    inValid <= 1'b0;
  endtask : send

  // key 0 means stream body, nul means replacement null packet
  task expect_pkt(input string what, input logic [15:0] p, input logic nul,
                  input logic [7:0] key);
    int w;
    int bad;
    logic [8:0] x;
    logic [7:0] e;
    logic [7:0] m;
    w = 0;
    bad = 0;
    while (obs.size() < 188 && w < 20000) begin
      @(posedge clk);
      w++;
    end
    if (obs.size() < 188) begin
      chk({what, " arrival"}, 20'd188, 20'(obs.size()));
      return;
    end
    chk({what, " start"}, 20'h1, 20'(obs[0][8]));
    for (int i = 0; i < 188; i++) begin
      x = obs.pop_front();
      e = i == 0 ? 8'h47 : i == 1 ? (nul ? 8'h1f : p[15:8]) : i == 2 ? (nul ? 8'hff : p[7:0]) :
          i == 3 ? 8'h10 : nul ? 8'hff : key ^ i[7:0];
      m = (nul && i == 1) ? 8'h1f : 8'hff;
      if ((x[7:0] & m) !== (e & m)) bad++;
    end
    chk(what, 20'd0, 20'(bad));
  endtask : expect_pkt

  task results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  initial begin
    #(60000 * 50);
    n_fail++;
    $display("mismatch watchdog expected done seen hung");
    results();
  end

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("idle outputs", 20'h0, {outValid_q, outClkCont_q});
    send(3'd0, 16'h0100);
    expect_pkt("unit off", 16'h0100, 1'b0, 8'h00);
    fill(0);
    fill(1);
    wrPid(4, 16'he100);
    wrPid(4 + 2 * 253, 16'h0100);
    wrPid(516, 16'ha200);
    wrPid(518, 16'h0301);
    wrPid(520, 16'h0100);
    wrPid(522, 16'h0444);
    for (int a = 1; a < 4; a++) cfg(a, 8'hff);
    cfg(1024, 8'h48);
    cfg(0, 8'h70);
    cfg(8192, 8'h00);
    cfgEnd();
    chk("clock bits", 20'h02, 20'(outClkCont_q));
    send(3'd0, 16'h0100);
    send(3'd0, 16'h4200);
    send(3'd0, 16'h0555);
    send(3'd1, 16'h0100);
    expect_pkt("remapped", 16'h4301, 1'b0, 8'h00);
    expect_pkt("same pid", 16'h0555, 1'b0, 8'h00);
    expect_pkt("other input", 16'h0100, 1'b0, 8'h00);
    chk("fifo refused", 20'h1, 20'(sawFull));
    repeat (600) @(posedge clk);
    cfg(0, 8'h60);
    cfgEnd();
    send(3'd0, 16'h0100);
    send(3'd0, 16'h0200);
    expect_pkt("allow list", 16'h0444, 1'b0, 8'h00);
    repeat (600) @(posedge clk);
    cfg(0, 8'h74);
    cfgEnd();
    send(3'd0, 16'h0100);
    expect_pkt("null swap", 16'h1fff, 1'b1, 8'h00);
    repeat (600) @(posedge clk);
    chk("stray packets", 20'h0, 20'(obs.size()));
    resetn <= 1'b0;
    slow <= 1'b1;
    tspf_flash_model_inst.build(8'd150);
    repeat (2) @(posedge clk);
    chk("reset outputs", 20'h0, {flashRd_q, outValid_q, outClkCont_q});
    resetn <= 1'b1;
    t0 = cyc;
    obs.delete();
    sopAt.delete();
    expect_pkt("table slot", 16'h0000, 1'b0, 8'h04);
    expect_pkt("user slot", 16'h0123, 1'b0, 8'h18);
    expect_pkt("table again", 16'h0000, 1'b0, 8'h04);
    chk("first wait", 20'h1, 20'(sopAt[0] >= 150 * TICK - 2));
    chk("no wait gap", 20'h1, 20'((sopAt[1] - sopAt[0]) < 150 * TICK));
    // gap holds the slow 188-byte send, the end slot and four skipped slots besides the wait
    chk("timed gap", 20'h1, 20'((sopAt[2] - sopAt[1]) >= 150 * TICK - 2 &&
                                 (sopAt[2] - sopAt[1]) <= 150 * TICK + 2500));
    results();
  end
endmodule : tspf_top_tb
`default_nettype wire

// ==== include/tspf_cfg.svh ====
// constants for the stream filter, remapper and table inserter
// assumes a 20 MHz core clock
`ifndef TSPF_CFG_SVH
`define TSPF_CFG_SVH
`define TSPF_REGION_BYTES 1024
`define TSPF_REGIONS      8
`define TSPF_IMAGE_BYTES  10000
`define TSPF_FILT_START   4
`define TSPF_FILT_ENTRIES 254
`define TSPF_REMAP_START  512
`define TSPF_REMAP_ENTRIES 128
`define TSPF_PID_BITS     13
`define TSPF_MODE_UNIT    6
`define TSPF_MODE_FILT    5
`define TSPF_MODE_DROP    4
`define TSPF_MODE_CLK     3
`define TSPF_MODE_NULL    2
`define TSPF_SLOTS        320
`define TSPF_SLOT_BYTES   204
`define TSPF_PKT_LEN      188
`define TSPF_CTL_INS      188
`define TSPF_CTL_TIME     189
`define TSPF_TIME_END     8'hff
`define TSPF_NULL_PID     13'h1fff
`define TSPF_TICK_NS      2000000
`define TSPF_CLK_NS       50
`define TSPF_TICK_CYC     (`TSPF_TICK_NS / `TSPF_CLK_NS)
`endif

// ==== include/tspf_pkg.sv ====
// types shared by the filter and inserter
// assumes tspf_cfg.svh is on the include path
`default_nettype none
package tspf_pkg;
  typedef struct packed {
    logic       sop;
    logic [2:0] port;
    logic [7:0] data;
  } tspf_word_t;
  typedef enum logic [2:0] {P_IDLE, P_HDR, P_SRCH, P_RMAP, P_EMIT, P_BODY, P_INS} tspf_proc_t;
  typedef enum logic [2:0] {I_CTL, I_DEC, I_WAIT, I_PEND, I_SEND} tspf_ins_t;
endpackage : tspf_pkg
`default_nettype wire

// ==== src/tspf_top.sv ====
// stream fifo plus per-input pid filter, remapper and table packet inserter
// assumes stream, config port and flash port are synchronous to clk
//
// Contract
// - 1024-byte region per input, in order
// - byte zero is mode, next three ignored
// - byte pairs from fifth byte are filters
// - remap entries from 512, in then out
// - only 13 pid bits matter
// - image bytes past eight regions ignored
// - 320 slots of 204 bytes in flash
// - erased flash inserts nothing
// - control byte 189 zero skips packet
// - byte 190 delays insertion N times 2ms
// - byte 190 of 255 restarts at zero
// - mode bits steer unit, filter, list, null, clock
// - 254 filters, duplicate pids act as one
// - remapper acts only on passed packets
// - remap to same pid leaves packet unchanged
`timescale 1ns/1ns
`default_nettype none
`include "tspf_cfg.svh"

module tspf_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             inValid,
  output var  logic             inReady,
  input  wire logic [WIDTH-1:0] inData,
  output var  logic             outValid,
  input  wire logic             outReady,
  output var  logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_q, rp_q;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;
  assign push = inValid && inReady;
  assign pop  = outValid && outReady;
  assign outValid = cnt_q != '0;
  assign outData  = mem[rp_q];
  always_comb begin
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= inData;
    end
  end
  // ready registered from the next count so it never admits into a full buffer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      inReady <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      inReady <= cnt_d != (AW+1)'(DEPTH);
    end
  end
endmodule : tspf_fifo

module tspf_top #(
  parameter int TICK_CYC = `TSPF_TICK_CYC,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire tspf_pkg::tspf_word_t inWord,
  input  wire logic                inValid,
  output var  logic                inReady,
  input  wire logic                cfgWe,
  input  wire logic [13:0]         cfgAddr,
  input  wire logic [7:0]          cfgData,
  output logic                     flashRd_q,
  output logic [19:0]              flashAddr_q,
  input  wire logic [7:0]          flashData,
  input  wire logic                flashValid,
  output logic                     outValid_q,
  output logic                     outSop_q,
  output logic [7:0]               outData_q,
  output logic [7:0]               outClkCont_q
);
  import tspf_pkg::*;
  localparam int PB = `TSPF_PID_BITS;

  tspf_word_t head;
  logic headValid, pop;
  tspf_fifo #(.WIDTH($bits(tspf_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk), .resetn(resetn), .inValid(inValid), .inReady(inReady),
    .inData(inWord), .outValid(headValid), .outReady(pop), .outData(head));

  // configuration store, word-organised so a lookup is one cycle per entry
  logic [7:0]    mode_q [`TSPF_REGIONS];
  logic [PB-1:0] filtPid [`TSPF_REGIONS*256];
  logic [PB-1:0] mapIn [`TSPF_REGIONS*128];
  logic [PB-1:0] mapOut [`TSPF_REGIONS*128];
  logic [2:0] cReg;
  logic [9:0] cOfs, fOfs, mOfs;
  assign cReg = cfgAddr[12:10];
  assign cOfs = cfgAddr[9:0];
  assign fOfs = cOfs - 10'(`TSPF_FILT_START);
  assign mOfs = cOfs - 10'(`TSPF_REMAP_START);
  always_ff @(posedge clk) begin
    // image bytes at 8192 and up are metadata only
    if (cfgWe && !cfgAddr[13]) begin
      if (cOfs >= 10'(`TSPF_REMAP_START)) begin
        case (mOfs[1:0])
          2'd0: mapIn[{cReg, mOfs[8:2]}][12:8] <= cfgData[4:0];
          2'd1: mapIn[{cReg, mOfs[8:2]}][7:0] <= cfgData;
          2'd2: mapOut[{cReg, mOfs[8:2]}][12:8] <= cfgData[4:0];
          default: mapOut[{cReg, mOfs[8:2]}][7:0] <= cfgData;
        endcase
      end else if (cOfs >= 10'(`TSPF_FILT_START)) begin
        if (!fOfs[0]) filtPid[{cReg, fOfs[8:1]}][12:8] <= cfgData[4:0];
        else filtPid[{cReg, fOfs[8:1]}][7:0] <= cfgData;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `TSPF_REGIONS; i++) mode_q[i] <= 8'h00;
    end else if (cfgWe && !cfgAddr[13] && cOfs == 10'h000) begin
      mode_q[cReg] <= cfgData;
    end
  end

  // packet processor
  tspf_proc_t pSt;
  tspf_ins_t iSt;
  logic [7:0] hdr_q [3];
  logic [1:0] hIdx_q;
  logic [2:0] port_q;
  logic [7:0] sIdx_q;
  logic [7:0] cnt_q;
  logic [PB-1:0] pid_q;
  logic hit_q, keep_q, nullMode_q, mapped_q;
  logic [7:0] md;
  logic unitOn, filtOn, dropList;
  assign md = mode_q[port_q];
  assign unitOn = md[`TSPF_MODE_UNIT];
  assign filtOn = md[`TSPF_MODE_FILT];
  assign dropList = md[`TSPF_MODE_DROP];
  assign pop = headValid && ((pSt == P_IDLE && !head.sop) || pSt == P_HDR ||
               (pSt == P_BODY && !head.sop));
  logic insGrant;
  assign insGrant = pSt == P_IDLE && iSt == I_PEND;
  logic filtHit, mapHit, keepNow;
  assign filtHit = filtPid[{port_q, sIdx_q}] == pid_q;
  assign mapHit = mapIn[{port_q, sIdx_q[6:0]}] == pid_q;
  assign keepNow = dropList ? !(hit_q || filtHit) : (hit_q || filtHit);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pSt <= P_IDLE;
      hIdx_q <= '0;
      sIdx_q <= '0;
      cnt_q <= '0;
      port_q <= '0;
      pid_q <= '0;
      hit_q <= 1'b0;
      keep_q <= 1'b1;
      nullMode_q <= 1'b0;
      mapped_q <= 1'b0;
      for (int i = 0; i < 3; i++) hdr_q[i] <= 8'h00;
    end else begin
      case (pSt)
        P_IDLE: begin
          hIdx_q <= '0;
          if (insGrant) pSt <= P_INS;
          else if (headValid && head.sop) pSt <= P_HDR;
        end
        P_HDR: if (headValid) begin
          hdr_q[hIdx_q] <= head.data;
          hIdx_q <= hIdx_q + 2'd1;
          if (hIdx_q == 2'd0) port_q <= head.port;
          if (hIdx_q == 2'd2) begin
            pid_q <= {hdr_q[1][4:0], head.data};
            // emit counts from zero, else a stray pid byte leads the packet
            hIdx_q <= '0;
            pSt <= P_SRCH;
            sIdx_q <= '0;
            hit_q <= 1'b0;
            keep_q <= 1'b1;
            nullMode_q <= 1'b0;
            mapped_q <= 1'b0;
          end
        end
        P_SRCH: begin
          // unit off passes untouched; filter off passes all but still remaps
          if (!unitOn) begin
            pSt <= P_EMIT;
          end else if (!filtOn) begin
            pSt <= P_RMAP;
          end else begin
            hit_q <= hit_q || filtHit;
            sIdx_q <= sIdx_q + 8'd1;
            if (sIdx_q == 8'(`TSPF_FILT_ENTRIES - 1)) begin
              sIdx_q <= '0;
              keep_q <= keepNow;
              nullMode_q <= !keepNow && md[`TSPF_MODE_NULL];
              if (keepNow) pSt <= P_RMAP;
              else begin
                pSt <= P_EMIT;
                if (md[`TSPF_MODE_NULL]) pid_q <= `TSPF_NULL_PID;
              end
            end
          end
        end
        P_RMAP: begin
          // first matching entry wins; same-pid entries rewrite to themselves
          sIdx_q <= sIdx_q + 8'd1;
          if (mapHit && !mapped_q) begin
            pid_q <= mapOut[{port_q, sIdx_q[6:0]}];
            mapped_q <= 1'b1;
          end
          if (sIdx_q == 8'(`TSPF_REMAP_ENTRIES - 1)) pSt <= P_EMIT;
        end
        P_EMIT: begin
          hIdx_q <= hIdx_q + 2'd1;
          cnt_q <= 8'd3;
          if (hIdx_q == 2'd2) pSt <= P_BODY;
        end
        P_BODY: if (headValid) begin
          if (head.sop) pSt <= P_IDLE;
          else cnt_q <= cnt_q + 8'd1;
        end
        P_INS: if (iSt != I_SEND) pSt <= P_IDLE;
        default: pSt <= P_IDLE;
      endcase
    end
  end

  // inserter: walks slots, honours control bytes, fetches on demand
  logic [8:0]  slot_q;
  logic [19:0] base_q;
  logic [7:0]  ctlIns_q, ctlTime_q, ticks_q, sendCnt_q;
  logic        ctlPhase_q, waitRd_q;
  logic [$clog2(TICK_CYC)-1:0] div_q;
  logic        tick;
  assign tick = div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= '0;
    end else if (iSt != I_WAIT || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      iSt <= I_CTL;
      slot_q <= '0;
      base_q <= '0;
      ctlIns_q <= 8'h00;
      ctlTime_q <= 8'h00;
      ticks_q <= 8'h00;
      sendCnt_q <= 8'h00;
      ctlPhase_q <= 1'b0;
      waitRd_q <= 1'b0;
      flashRd_q <= 1'b0;
      flashAddr_q <= '0;
    end else begin
      flashRd_q <= 1'b0;
      case (iSt)
        I_CTL: begin
          if (!waitRd_q) begin
            flashRd_q <= 1'b1;
            flashAddr_q <= base_q + 20'(ctlPhase_q ? `TSPF_CTL_TIME : `TSPF_CTL_INS);
            waitRd_q <= 1'b1;
          end else if (flashValid) begin
            waitRd_q <= 1'b0;
            ctlPhase_q <= !ctlPhase_q;
            if (!ctlPhase_q) ctlIns_q <= flashData;
            else begin
              ctlTime_q <= flashData;
              iSt <= I_DEC;
            end
          end
        end
        I_DEC: begin
          ticks_q <= ctlTime_q;
          if (ctlTime_q == `TSPF_TIME_END) begin
            slot_q <= '0;
            base_q <= '0;
            iSt <= I_CTL;
          end else if (ctlIns_q == 8'h00) begin
            iSt <= I_CTL;
            if (slot_q == 9'(`TSPF_SLOTS - 1)) begin
              slot_q <= '0;
              base_q <= '0;
            end else begin
              slot_q <= slot_q + 9'd1;
              base_q <= base_q + 20'(`TSPF_SLOT_BYTES);
            end
          end else if (ctlTime_q == 8'h00) iSt <= I_PEND;
          else iSt <= I_WAIT;
        end
        I_WAIT: if (tick) begin
          ticks_q <= ticks_q - 8'd1;
          if (ticks_q == 8'd1) iSt <= I_PEND;
        end
        I_PEND: if (insGrant) begin
          iSt <= I_SEND;
          sendCnt_q <= '0;
        end
        I_SEND: begin
          if (!waitRd_q) begin
            flashRd_q <= 1'b1;
            flashAddr_q <= base_q + 20'(sendCnt_q);
            waitRd_q <= 1'b1;
          end else if (flashValid) begin
            waitRd_q <= 1'b0;
            sendCnt_q <= sendCnt_q + 8'd1;
            if (sendCnt_q == 8'(`TSPF_PKT_LEN - 1)) begin
              iSt <= I_CTL;
              if (slot_q == 9'(`TSPF_SLOTS - 1)) begin
                slot_q <= '0;
                base_q <= '0;
              end else begin
                slot_q <= slot_q + 9'd1;
                base_q <= base_q + 20'(`TSPF_SLOT_BYTES);
              end
            end
          end
        end
        default: iSt <= I_CTL;
      endcase
    end
  end

  // output stream; dropped packets vanish unless the null changer is on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outValid_q <= 1'b0;
      outSop_q <= 1'b0;
      outData_q <= 8'h00;
      outClkCont_q <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) outClkCont_q[i] <= mode_q[i][`TSPF_MODE_CLK];
      outValid_q <= 1'b0;
      outSop_q <= 1'b0;
      if (pSt == P_EMIT && (keep_q || nullMode_q)) begin
        outValid_q <= 1'b1;
        outSop_q <= hIdx_q == 2'd0;
        case (hIdx_q)
          2'd0: outData_q <= hdr_q[0];
          2'd1: outData_q <= {hdr_q[1][7:5], pid_q[12:8]};
          default: outData_q <= pid_q[7:0];
        endcase
      end else if (pSt == P_BODY && pop && (keep_q || nullMode_q)) begin
        outValid_q <= 1'b1;
        outData_q <= !nullMode_q ? head.data : (cnt_q == 8'd3 ? 8'h10 : 8'hff);
      end else if (iSt == I_SEND && waitRd_q && flashValid) begin
        outValid_q <= 1'b1;
        outSop_q <= sendCnt_q == 8'h00;
        outData_q <= flashData;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_end_restart: assert property ((iSt == I_DEC && ctlTime_q == 8'hff) |=> slot_q == 9'd0 && base_q == 20'd0) else $error("end marker did not restart");
  chk_skip_zero: assert property ((iSt == I_DEC && ctlTime_q != 8'hff && ctlIns_q == 8'h00) |=> iSt == I_CTL) else $error("skipped slot still pending");
  chk_erased_quiet: assert property (iSt == I_SEND |-> ctlTime_q != 8'hff && ctlIns_q != 8'h00) else $error("insertion with end or skip byte");
  chk_prompt_insert: assert property ((iSt == I_DEC && ctlIns_q != 8'h00 && ctlTime_q == 8'h00) |=> iSt == I_PEND) else $error("prompt insertion delayed");
  chk_wait_count: assert property ((iSt == I_WAIT && tick && ticks_q > 8'd1) |=> iSt == I_WAIT && ticks_q == $past(ticks_q) - 8'd1) else $error("delay tick miscounted");
  chk_filter_bound: assert property (pSt == P_SRCH |-> sIdx_q < 8'd254) else $error("filter index out of range");
  chk_remap_passed: assert property (pSt == P_RMAP |-> keep_q) else $error("remap on dropped packet");
  chk_pid_upper: assert property ((pSt == P_EMIT && hIdx_q == 2'd1 && keep_q) |=> outValid_q && outData_q[7:5] == $past(hdr_q[1][7:5])) else $error("flag bits above pid changed");
  chk_insert_slot: assert property ((pSt == P_INS) |-> iSt == I_SEND || $past(iSt) == I_SEND) else $error("insert without send");
  cov_insert: cover property (iSt == I_SEND ##1 iSt == I_CTL);
  cov_null_drop: cover property (pSt == P_EMIT && nullMode_q);
  cov_remap: cover property (pSt == P_RMAP && mapHit && !mapped_q);
  cov_restart: cover property (iSt == I_DEC && ctlTime_q == 8'hff);
endmodule : tspf_top
`default_nettype wire
